/* logic/tpc_unit.sv */
// Sixteen-bit timer with one period register and one capture channel.
// Assumes one clock, a synchronous active-low reset, and a register master that
// issues one-cycle strobes and takes read data in the following cycle.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_map.svh"

module tpc_unit
   import tpc_pkg::*;
(
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Register port.
   input  wire tpc_bus_t   bus,
   output var  logic [7:0] rdata,
   // Capture pin, as input, output and output enable.
   input  wire logic       cap_pin_in,
   output var  logic       cap_pin_out,
   output var  logic       cap_pin_oe_n,
   // Interrupt request.
   output var  logic       irq
);

   // ************************************************************
   // Functions
   // ************************************************************

   // Byte lane of a 16-bit word chosen by the low or high offset.
   function automatic logic [7:0] byte_of(input logic [`TPC_TW-1:0] w, input logic hi);
      byte_of = hi ? w[15:8] : w[7:0];
   endfunction : byte_of

   // Replaces one byte of a 16-bit word; used for period and timer writes.
   function automatic logic [`TPC_TW-1:0] put_byte(input logic [`TPC_TW-1:0] w,
                                                   input logic [7:0] b, input logic hi);
      put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
   endfunction : put_byte

   // Read mux; unmapped addresses answer zero.
   // Unused bits of every register read back as zero, so software may test whole bytes.
   function automatic logic [7:0] read_mux(input logic [3:0] a, input tpc_state_t s);
      read_mux = `TPC_BYTE_ZERO;
      case (a)
         `TPC_OFS_PER_LO   : read_mux = byte_of(s.period, 1'b0);
         `TPC_OFS_PER_HI   : read_mux = byte_of(s.period, 1'b1);
         `TPC_OFS_CAP_LO   : read_mux = byte_of(s.cap, 1'b0);
         `TPC_OFS_CAP_HI   : read_mux = byte_of(s.cap, 1'b1);
         `TPC_OFS_TMR_LO   : read_mux = byte_of(s.timer, 1'b0);
         `TPC_OFS_TMR_HI   : read_mux = byte_of(s.timer, 1'b1);
         `TPC_OFS_CTRL     : begin
            read_mux[`TPC_CTL_SEL]     = s.sel;
            read_mux[`TPC_CTL_EDGE_LO] = s.edge_sel[0];
            read_mux[`TPC_CTL_EDGE_HI] = s.edge_sel[1];
            read_mux[`TPC_CTL_RUN]     = s.run;
            read_mux[`TPC_CTL_OVF]     = s.ovf;
         end
         `TPC_OFS_FLAGS    : read_mux[2:0] = s.flags;
         `TPC_OFS_MASK     : read_mux[2:0] = s.mask;
         `TPC_OFS_IRQ_CTRL : begin
            read_mux[`TPC_IRQ_PIE] = s.pie;
            read_mux[`TPC_IRQ_GID] = s.gid;
         end
         `TPC_OFS_PIN_CTRL : begin
            read_mux[`TPC_PIN_DIR] = s.pin_dir;
            read_mux[`TPC_PIN_LAT] = s.pin_lat;
         end
         default           : read_mux = `TPC_BYTE_ZERO;
      endcase
   endfunction : read_mux

   // ************************************************************
   // State and decodes
   // ************************************************************

   tpc_state_t s_r;
   tpc_state_t s_nxt;

   // Strobe decodes, shared by the next-state logic and the checks.
   logic wr_per_lo;
   logic wr_per_hi;
   logic wr_tmr_lo;
   logic wr_tmr_hi;
   logic rd_cap_lo;
   logic rd_cap_hi;
   logic both_read;
   logic pin_src;
   logic rise;
   logic fall;
   logic cap_evt;
   logic tmr_match;

   // Register port decodes.
   assign wr_per_lo = bus.wr && (bus.addr == `TPC_OFS_PER_LO);
   assign wr_per_hi = bus.wr && (bus.addr == `TPC_OFS_PER_HI);
   assign wr_tmr_lo = bus.wr && (bus.addr == `TPC_OFS_TMR_LO);
   assign wr_tmr_hi = bus.wr && (bus.addr == `TPC_OFS_TMR_HI);
   assign rd_cap_lo = bus.rd && (bus.addr == `TPC_OFS_CAP_LO);
   assign rd_cap_hi = bus.rd && (bus.addr == `TPC_OFS_CAP_HI);

   // Both bytes now read in either order; only meaningful while a word waits.
   // A repeated read of the same byte changes nothing; only the pair counts.
   assign both_read = s_r.unread && (rd_cap_lo || rd_cap_hi)
                      && (s_r.seen_lo || rd_cap_lo) && (s_r.seen_hi || rd_cap_hi);

   // When the pin is an output, its own latch is what the capture logic sees.
   // This lets software fake a capture while the pin is driven, which helps bring-up.
   assign pin_src = s_r.pin_dir ? s_r.pin_lat : cap_pin_in;

   // Edges come from the second and third stages only, never the first.
   assign rise = s_r.sync2 && !s_r.sync3;
   assign fall = !s_r.sync2 && s_r.sync3;

   // Qualified capture event; the prescaler compare uses the count before this edge.
   always_comb begin
      unique case (s_r.edge_sel)
         TPC_EDGE_FALL   : cap_evt = fall;
         TPC_EDGE_RISE   : cap_evt = rise;
         TPC_EDGE_RISE4  : cap_evt = rise && (s_r.presc[1:0] == 2'(`TPC_DIV4_LAST));
         TPC_EDGE_RISE16 : cap_evt = rise && (s_r.presc == `TPC_DIV16_LAST);
      endcase
   end

   // Period match is only meaningful in period mode.
   // With select set the timer free-runs and never raises the match flag.
   assign tmr_match = s_r.run && !s_r.sel && (s_r.timer == s_r.period);

   // ************************************************************
   // Next state
   // ************************************************************

   // All behaviour of the unit in one place; register writes take effect at the edge.
   always_comb begin
      logic [2:0] set_flags;
      logic [2:0] clr_flags;
      set_flags = 3'b000;
      clr_flags = 3'b000;
      s_nxt     = s_r;

      // Synchroniser for the capture pin, then the edge history stage.
      // A level held for less than one clock can slip past the sampler unseen.
      s_nxt.sync1 = pin_src;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;

      // Prescaler counts every rising edge and is never reset by a mode change.
      // A new edge choice inherits the running count, so its first event can come early.
      if (rise) begin
         s_nxt.presc = s_r.presc + `TPC_PRE_ONE;
      end

      // Timer: count, wrap after the period value, or free-run in the other mode.
      if (tmr_match) begin
         s_nxt.timer             = `TPC_WORD_ZERO;
         set_flags[`TPC_FLG_TMR] = 1'b1;
      end else if (s_r.run) begin
         s_nxt.timer = s_r.timer + `TPC_TW'(1);
      end
      if (wr_tmr_lo || wr_tmr_hi) begin
         s_nxt.timer = put_byte(s_r.timer, bus.wdata, wr_tmr_hi);
      end

      // Period register built from the two byte writes.
      if (wr_per_lo || wr_per_hi) begin
         s_nxt.period = put_byte(s_r.period, bus.wdata, wr_per_hi);
      end

      // Completed read of both bytes publishes the overflow and frees the register.
      if (both_read) begin
         s_nxt.ovf     = s_r.master;
         s_nxt.master  = 1'b0;
         s_nxt.unread  = 1'b0;
         s_nxt.seen_lo = 1'b0;
         s_nxt.seen_hi = 1'b0;
      end else if (s_r.unread) begin
         s_nxt.seen_lo = s_r.seen_lo || rd_cap_lo;
         s_nxt.seen_hi = s_r.seen_hi || rd_cap_hi;
      end

      // Capture: an event that finds a waiting word only marks overflow, and wins
      // over a clear in the same cycle so that no overrun goes unseen.
      // Copying all sixteen bits in one edge means the two byte reads can never tear.
      if (cap_evt) begin
         set_flags[`TPC_FLG_CAP2] = 1'b1;
         if (s_r.unread) begin
            s_nxt.master = 1'b1;
         end else begin
            s_nxt.cap     = s_r.timer;
            s_nxt.unread  = 1'b1;
            s_nxt.seen_lo = 1'b0;
            s_nxt.seen_hi = 1'b0;
         end
      end

      // Register writes; the flags clear by writing ones.
      if (bus.wr) begin
         unique case (bus.addr)
            `TPC_OFS_CTRL     : begin
               s_nxt.sel      = bus.wdata[`TPC_CTL_SEL];
               s_nxt.edge_sel = tpc_edge_t'(bus.wdata[`TPC_CTL_EDGE_HI:`TPC_CTL_EDGE_LO]);
               s_nxt.run      = bus.wdata[`TPC_CTL_RUN];
            end
            `TPC_OFS_FLAGS    : clr_flags = bus.wdata[2:0];
            `TPC_OFS_MASK     : s_nxt.mask = bus.wdata[2:0];
            `TPC_OFS_IRQ_CTRL : begin
               s_nxt.pie = bus.wdata[`TPC_IRQ_PIE];
               s_nxt.gid = bus.wdata[`TPC_IRQ_GID];
            end
            `TPC_OFS_PIN_CTRL : begin
               s_nxt.pin_dir = bus.wdata[`TPC_PIN_DIR];
               s_nxt.pin_lat = bus.wdata[`TPC_PIN_LAT];
            end
            default           : ;
         endcase
      end

      // Sticky flags: set beats clear; the first channel flag never sets here.
      s_nxt.flags                = (s_r.flags & ~clr_flags) | set_flags;
      s_nxt.flags[`TPC_FLG_CAP1] = 1'b0;

      // Read data for the cycle after the strobe.
      // Zero outside the answer cycle lets several read ports be ORed together.
      s_nxt.rdata = bus.rd ? read_mux(bus.addr, s_r) : `TPC_BYTE_ZERO;

      // Interrupt needs an unmasked flag, the peripheral enable and no global disable.
      // Working from the next state saves one cycle of interrupt latency.
      s_nxt.irq = (|(s_nxt.flags & s_nxt.mask)) && s_nxt.pie && !s_nxt.gid;
   end

   // ************************************************************
   // State register
   // ************************************************************

   // Synchronous reset puts every field, the prescaler among them, to a constant.
   // Reset leaves the global disable set, so nothing interrupts before software is ready.
   // A reset branch of constants only keeps the clear free of logic that could be unknown.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_r          <= '0;
         s_r.period   <= `TPC_PER_RST;
         s_r.edge_sel <= TPC_EDGE_FALL;
         s_r.gid      <= 1'b1;
         s_r.presc    <= `TPC_PRE_ZERO;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign rdata        = s_r.rdata;
   assign irq          = s_r.irq;
   assign cap_pin_out  = s_r.pin_lat;
   assign cap_pin_oe_n = !s_r.pin_dir;

   // ************************************************************
   // Checks
   // ************************************************************

   // Every check rests while reset is low, so reset values need no special case.
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Timer returns to zero right after matching the period.
   timer_wrap_a : assert property (tmr_match && !wr_tmr_lo && !wr_tmr_hi
                                   |=> s_r.timer == `TPC_WORD_ZERO)
      else $error("timer did not wrap after period match");

   // Match raises the timer flag in the next cycle.
   match_flag_a : assert property (tmr_match |=> s_r.flags[`TPC_FLG_TMR])
      else $error("timer flag missing after match");

   // The first capture flag stays clear.
   first_idle_a : assert property (!s_r.flags[`TPC_FLG_CAP1])
      else $error("first capture flag became set");

   // A clean event stores the timer value it saw.
   capture_copy_a : assert property (cap_evt && !s_r.unread
                                     |=> s_r.cap == $past(s_r.timer) && s_r.unread)
      else $error("capture did not copy the timer");

   // An overrun keeps the old word and sets the master bit.
   overrun_keep_a : assert property (cap_evt && s_r.unread && !both_read
                                     |=> $stable(s_r.cap) && s_r.master)
      else $error("overrun changed capture or missed master bit");

   // Finishing the byte pair publishes and clears the master bit.
   ovf_publish_a : assert property (both_read && !cap_evt
                                    |=> s_r.ovf == $past(s_r.master) && !s_r.master)
      else $error("overflow not published after both reads");

   // Interrupt never rises without its gates.
   irq_gate_a : assert property (irq |-> s_r.pie && !s_r.gid)
      else $error("interrupt without peripheral enable or with global disable");

   // Sixteenth-edge mode fires only on a full prescaler count.
   div16_event_a : assert property (cap_evt && s_r.edge_sel == TPC_EDGE_RISE16
                                    |-> rise && s_r.presc == `TPC_DIV16_LAST)
      else $error("sixteenth-edge event at wrong count");

   // Prescaler leaves reset cleared.
   presc_reset_a : assert property ($rose(rst_n) |-> s_r.presc == `TPC_PRE_ZERO)
      else $error("prescaler not cleared by reset");

   // A capture flag follows each event.
   cap_flag_a : assert property (cap_evt |=> s_r.flags[`TPC_FLG_CAP2])
      else $error("capture flag missing after event");

   // The first stage feeds the second, and the second the edge stage.
   sync_chain_a : assert property (s_r.sync2 == $past(s_r.sync1) && s_r.sync3 == $past(s_r.sync2))
      else $error("capture pin synchroniser skipped a stage");

   // The interrupt line follows the gated, masked flags.
   irq_level_a : assert property (irq == ((|(s_r.flags & s_r.mask)) && s_r.pie && !s_r.gid))
      else $error("interrupt level disagrees with flags and gates");

   // Without a rising edge the prescaler keeps its count, even across a mode change.
   presc_hold_a : assert property (!rise |=> $stable(s_r.presc))
      else $error("prescaler changed without a rising edge");

   // Each rising edge advances the prescaler by one.
   presc_step_a : assert property (rise |=> (s_r.presc - $past(s_r.presc)) == `TPC_PRE_ONE)
      else $error("prescaler did not advance on a rising edge");

   // The timer flag rises only through a period match.
   tmr_flag_only_a : assert property (!tmr_match && !s_r.flags[`TPC_FLG_TMR] |=> !s_r.flags[`TPC_FLG_TMR])
      else $error("timer flag set without a match");

   // The capture flag rises only through a capture event.
   cap_flag_only_a : assert property (!cap_evt && !s_r.flags[`TPC_FLG_CAP2] |=> !s_r.flags[`TPC_FLG_CAP2])
      else $error("capture flag set without an event");

   // The visible overflow bit moves only when a byte pair completes.
   ovf_hold_a : assert property (!both_read |=> $stable(s_r.ovf))
      else $error("visible overflow changed outside a completed pair");

   // Between matches the running timer steps by one unless software writes it.
   timer_step_a : assert property (s_r.run && !tmr_match && !wr_tmr_lo && !wr_tmr_hi
                                   |=> s_r.timer == `TPC_TW'($past(s_r.timer) + `TPC_TW'(1)))
      else $error("timer did not step by one");

   // A stopped timer keeps its value unless software writes it.
   timer_hold_a : assert property (!s_r.run && !wr_tmr_lo && !wr_tmr_hi |=> $stable(s_r.timer))
      else $error("stopped timer changed");

   // Main scenarios.
   wrap_c     : cover property (tmr_match ##1 s_r.timer == `TPC_WORD_ZERO);
   capture_c  : cover property (cap_evt && !s_r.unread);
   overrun_c  : cover property (cap_evt && s_r.unread ##[1:50] both_read);
   irq_c      : cover property ($rose(irq));
   ovf_pub_c  : cover property (both_read && s_r.master);

endmodule : tpc_unit

`default_nettype wire

/* logic/tpc_map.svh */
// Register offsets, field positions, reset values and counts of the timer period capture unit.
// Assumes inclusion by bare name from the package and from the unit itself.
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// Register offsets on the 4-bit byte address port.
`define TPC_OFS_PER_LO    4'h0
`define TPC_OFS_PER_HI    4'h1
`define TPC_OFS_CAP_LO    4'h2
`define TPC_OFS_CAP_HI    4'h3
`define TPC_OFS_TMR_LO    4'h4
`define TPC_OFS_TMR_HI    4'h5
`define TPC_OFS_CTRL      4'h6
`define TPC_OFS_FLAGS     4'h7
`define TPC_OFS_MASK      4'h8
`define TPC_OFS_IRQ_CTRL  4'h9
`define TPC_OFS_PIN_CTRL  4'hA

// Bit positions in the control register (timer_control_two).
`define TPC_CTL_SEL       0
`define TPC_CTL_EDGE_LO   1
`define TPC_CTL_EDGE_HI   2
`define TPC_CTL_RUN       3
`define TPC_CTL_OVF       4

// Bit positions in the flag and mask registers.
`define TPC_FLG_TMR       0
`define TPC_FLG_CAP1      1
`define TPC_FLG_CAP2      2

// Bit positions in the interrupt control and pin control registers.
`define TPC_IRQ_PIE       0
`define TPC_IRQ_GID       1
`define TPC_PIN_DIR       0
`define TPC_PIN_LAT       1

// Widths, reset values and prescaler terminal counts.
`define TPC_TW            16
`define TPC_BYTE_ZERO     8'h00
`define TPC_WORD_ZERO     16'h0000
`define TPC_PER_RST       16'hFFFF
`define TPC_DIV4_LAST     4'h3
`define TPC_DIV16_LAST    4'hF
`define TPC_PRE_ZERO      4'h0
`define TPC_PRE_ONE       4'h1

`endif

/* logic/tpc_pkg.sv */
// Types shared by the timer period capture unit.
// Assumes tpc_map.svh is on the include path.
`default_nettype none
`include "tpc_map.svh"

package tpc_pkg;

   // Edge selection of the second capture channel.
   typedef enum logic [1:0] {
      TPC_EDGE_FALL   = 2'b00,
      TPC_EDGE_RISE   = 2'b01,
      TPC_EDGE_RISE4  = 2'b10,
      TPC_EDGE_RISE16 = 2'b11
   } tpc_edge_t;

   // One request on the register port.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tpc_bus_t;

   // Whole state of the unit, registered as one word.
   typedef struct packed {
      logic [`TPC_TW-1:0] timer;
      logic [`TPC_TW-1:0] period;
      logic [`TPC_TW-1:0] cap;
      logic               sel;
      tpc_edge_t          edge_sel;
      logic               run;
      logic               pie;
      logic               gid;
      logic [2:0]         flags;
      logic [2:0]         mask;
      logic               unread;
      logic               master;
      logic               ovf;
      logic               seen_lo;
      logic               seen_hi;
      logic [3:0]         presc;
      logic               sync1;
      logic               sync2;
      logic               sync3;
      logic               pin_dir;
      logic               pin_lat;
      logic [7:0]         rdata;
      logic               irq;
   } tpc_state_t;

endpackage : tpc_pkg

`default_nettype wire

/* verif/tpc_pin_src.sv */
// External event source that stands on the capture pin of the timer period capture unit.
// Assumes the unit's pin output and its active-low output enable are fed back here.
`timescale 1ns/1ps
`default_nettype none

module tpc_pin_src (
   // Clock.
   input  wire logic core_clk,
   // Pin as the unit sees it.
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   output wire logic pin_in
);
   logic ext_lvl = 1'b0;

   // The source lets go while the unit drives, so the wire follows the unit then.
   assign pin_in = pin_oe_n ? ext_lvl : pin_out;

   // Levels last three cycles or more, because the unit samples the pin through flops.
   task automatic put(input logic v, input int unsigned hold);
      @(posedge core_clk);
      ext_lvl <= v;
      repeat (hold + 2) @(posedge core_clk);
   endtask : put

   // Whole pulses, each one high and then low.
   task automatic pulses(input int unsigned n, input int unsigned hold);
      repeat (n) begin
         put(1'b1, hold);
         put(1'b0, hold);
      end
   endtask : pulses
endmodule : tpc_pin_src
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the timer period capture unit.
// Assumes tpc_pkg, the unit and the pin source model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_map.svh"

module tb_top
   import tpc_pkg::*;
;
   // ****************
   // Signals.
   // ****************
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b0;
   tpc_bus_t    bus      = '0;
   logic [7:0]  rdata;
   wire logic   cap_pin_in;
   logic        cap_pin_out;
   logic        cap_pin_oe_n;
   logic        irq;
   logic        rd_seen  = 1'b0;
   logic [7:0]  exp_q[$];
   int          n_errors = 0;
   int          checked  = 0;
   int          cycles   = 0;
   logic [15:0] t;
   logic [15:0] b;
   int          w;

   tpc_unit uut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .cap_pin_in(cap_pin_in),
                 .cap_pin_out(cap_pin_out), .cap_pin_oe_n(cap_pin_oe_n), .irq(irq));
   tpc_pin_src pm (.core_clk(core_clk), .pin_out(cap_pin_out), .pin_oe_n(cap_pin_oe_n), .pin_in(cap_pin_in));

   // Clock of 10 ns.
   always #5 core_clk = ~core_clk;

   // ****************
   // Checking.
   // ****************
   task automatic bad(input string m);
      n_errors++;
      $display("BAD %0t %s", $time, m);
   endtask : bad

   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) bad($sformatf("rdata %h expected %h", g, e));
   endtask : cmp_byte

   task automatic cmp_irq(input logic e);
      @(negedge core_clk);
      checked++;
      if (irq !== e) bad("interrupt level");
   endtask : cmp_irq

   task automatic cmp_pin(input logic e_out, input logic e_oe_n);
      @(negedge core_clk);
      checked++;
      if ({cap_pin_out, cap_pin_oe_n} !== {e_out, e_oe_n}) bad("pin output or enable");
   endtask : cmp_pin

   task automatic summarize();
      if (n_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // Read data are due one cycle after the strobe; the oldest note is taken then.
   always @(posedge core_clk) rd_seen <= bus.rd;
   always @(negedge core_clk) begin
      if (rd_seen) begin
         if (exp_q.size() == 0)
            bad("read data without a note");
         else
            cmp_byte(rdata, exp_q.pop_front());
      end else if (cycles > 2) begin
         cmp_byte(rdata, 8'h00);
      end
   end

   // A hang ends the run through the same report.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad("timeout");
         summarize();
      end
   end

   // ****************
   // Bus tasks.
   // ****************
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      exp_q.push_back(e);
      @(posedge core_clk);
      bus.rd <= 1'b0;
   endtask : rd

   task automatic rd_cap(input logic [15:0] v, input logic hi_first);
      if (hi_first) begin
         rd(`TPC_OFS_CAP_HI, v[15:8]);
         rd(`TPC_OFS_CAP_LO, v[7:0]);
      end else begin
         rd(`TPC_OFS_CAP_LO, v[7:0]);
         rd(`TPC_OFS_CAP_HI, v[15:8]);
      end
   endtask : rd_cap

   task automatic set_tmr(input logic [15:0] v);
      wr(`TPC_OFS_TMR_LO, v[7:0]);
      wr(`TPC_OFS_TMR_HI, v[15:8]);
   endtask : set_tmr

   // Three cycles of reset, then every mapped place and one unmapped one.
   task automatic reset_and_check();
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 12; i++)
         rd(4'(i), (i < 2) ? 8'hFF : (i == `TPC_OFS_IRQ_CTRL) ? 8'h02 : 8'h00);
      cmp_irq(1'b0);
      cmp_pin(1'b0, 1'b1);
   endtask : reset_and_check

   // ****************
   // Scenarios.
   // ****************
   initial begin
      void'($urandom(32'h3337));
      reset_and_check();
      wr(4'hB, 8'h5A);
      rd(4'hB, 8'h00);
      // Period of five, run for a random span, then stop; the count wraps through zero.
      wr(`TPC_OFS_PER_LO, 8'h05);
      wr(`TPC_OFS_PER_HI, 8'h00);
      w = 6 + $urandom_range(14);
      wr(`TPC_OFS_CTRL, 8'h08);
      repeat (w) @(posedge core_clk);
      wr(`TPC_OFS_CTRL, 8'h00);
      rd(`TPC_OFS_TMR_LO, 8'((w + 2) % 6));
      rd(`TPC_OFS_TMR_HI, 8'h00);
      rd(`TPC_OFS_FLAGS, 8'h01);
      for (int c = 0; c < 8; c++) begin
         wr(`TPC_OFS_MASK, {7'h00, c[0]});
         wr(`TPC_OFS_IRQ_CTRL, {6'h00, c[2], c[1]});
         repeat (2) @(posedge core_clk);
         cmp_irq(c[0] & c[1] & ~c[2]);
      end
      wr(`TPC_OFS_IRQ_CTRL, 8'h01);
      repeat (2) @(posedge core_clk);
      cmp_irq(1'b1);
      wr(`TPC_OFS_FLAGS, 8'h01);
      repeat (2) @(posedge core_clk);
      cmp_irq(1'b0);
      rd(`TPC_OFS_FLAGS, 8'h00);
      wr(`TPC_OFS_MASK, 8'h00);
      // Every edge code with the timer frozen, so the captured word is known exactly.
      for (int k = 0; k < 4; k++) begin
         t = 16'($urandom);
         set_tmr(t);
         wr(`TPC_OFS_CTRL, {5'h00, 2'(k), 1'b0});
         if (k < 2) begin
            pm.put(1'b1, $urandom_range(3));
            repeat (6) @(posedge core_clk);
            rd(`TPC_OFS_FLAGS, (k == 1) ? 8'h04 : 8'h00);
            pm.put(1'b0, $urandom_range(3));
         end else begin
            pm.pulses((k == 2) ? 4 : 16, $urandom_range(3));
         end
         repeat (6) @(posedge core_clk);
         rd(`TPC_OFS_FLAGS, 8'h04);
         wr(`TPC_OFS_FLAGS, 8'h04);
         wr(`TPC_OFS_CAP_LO, 8'hA5);
         rd_cap(t, k[0]);
         rd(`TPC_OFS_CTRL, {5'h00, 2'(k), 1'b0});
      end
      // A second event before the word is read keeps the first word and sets overflow.
      t = 16'($urandom);
      b = ~t;
      wr(`TPC_OFS_CTRL, 8'h02);
      set_tmr(t);
      pm.pulses(1, 0);
      set_tmr(b);
      pm.pulses(1, 2);
      repeat (6) @(posedge core_clk);
      rd(`TPC_OFS_CTRL, 8'h02);
      rd(`TPC_OFS_CAP_LO, t[7:0]);
      rd(`TPC_OFS_CAP_LO, t[7:0]);
      rd(`TPC_OFS_CTRL, 8'h02);
      rd(`TPC_OFS_CAP_HI, t[15:8]);
      rd(`TPC_OFS_CTRL, 8'h12);
      pm.pulses(1, 1);
      repeat (6) @(posedge core_clk);
      rd_cap(b, 1'b1);
      rd(`TPC_OFS_CTRL, 8'h02);
      wr(`TPC_OFS_FLAGS, 8'h04);
      // Driving the pin as an output makes the capture from the latch.
      t = 16'($urandom);
      set_tmr(t);
      wr(`TPC_OFS_MASK, 8'h04);
      cmp_irq(1'b0);
      wr(`TPC_OFS_PIN_CTRL, 8'h01);
      cmp_pin(1'b0, 1'b0);
      wr(`TPC_OFS_PIN_CTRL, 8'h03);
      cmp_pin(1'b1, 1'b0);
      repeat (6) @(posedge core_clk);
      cmp_irq(1'b1);
      rd_cap(t, 1'b0);
      wr(`TPC_OFS_MASK, 8'h00);
      repeat (2) @(posedge core_clk);
      cmp_irq(1'b0);
      wr(`TPC_OFS_PIN_CTRL, 8'h00);
      cmp_pin(1'b0, 1'b1);
      // Reset in mid-run clears the prescaler: the fourth rise is the first event.
      // The reset is launched at a rising edge like every other input.
      @(posedge core_clk);
      reset_and_check();
      wr(`TPC_OFS_CTRL, 8'h04);
      pm.pulses(3, 1);
      repeat (6) @(posedge core_clk);
      rd(`TPC_OFS_FLAGS, 8'h00);
      pm.pulses(1, 1);
      repeat (6) @(posedge core_clk);
      rd(`TPC_OFS_FLAGS, 8'h04);
      repeat (3) @(posedge core_clk);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
